// [logic/wdt_watchdog_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_watchdog_timer
   import wdt_pkg::*;
#(
   parameter int unsigned TIMEOUT_CLKS_0 = `WDT_TIMEOUT_0,
   parameter int unsigned TIMEOUT_CLKS_1 = `WDT_TIMEOUT_1,
   parameter int unsigned TIMEOUT_CLKS_2 = `WDT_TIMEOUT_2,
   parameter int unsigned TIMEOUT_CLKS_3 = `WDT_TIMEOUT_3
) (
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   input  wire logic [2:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output var  logic [31:0] avs_readdata,
   output wire logic        avs_waitrequest,
   output var  logic        irq,
   output var  logic        timeout_irq_req,
   output var  logic        wd_sys_reset
);

   localparam int unsigned TO0_LAST    = TIMEOUT_CLKS_0 - 1;
   localparam int unsigned TO1_LAST    = TIMEOUT_CLKS_1 - 1;
   localparam int unsigned TO2_LAST    = TIMEOUT_CLKS_2 - 1;
   localparam int unsigned TO3_LAST    = TIMEOUT_CLKS_3 - 1;
   localparam int          GRACE_LAST  = `WDT_GRACE_CLKS - 1;
   localparam int          HOLD_LAST   = `WDT_HOLD_CLKS - 1;

   // register state
   wdt_state_t                  state_reg;
   wdt_state_t                  state_next;
   logic                        run_reg;
   logic                        run_next;
   logic [1:0]                  sel_reg;
   logic [1:0]                  sel_next;
   logic                        flag_reg;
   logic                        flag_next;
   logic                        cause_reg;
   logic                        cause_next;
   logic                        rst_en_reg;
   logic                        rst_en_next;
   logic                        ext_en_reg;
   logic                        ext_en_next;
   logic                        glb_en_reg;
   logic                        glb_en_next;
   logic [`WDT_EV_W-1:0]        stat_reg;
   logic [`WDT_EV_W-1:0]        stat_next;
   logic [`WDT_EV_W-1:0]        mask_reg;
   logic [`WDT_EV_W-1:0]        mask_next;
   logic                        ack_reg;
   logic [31:0]                 rdata_reg;

   // avalon slave: one wait cycle, access completes at the second edge
   wire        bus_req     = avs_read | avs_write;
   wire        bus_done    = bus_req & ack_reg;
   wire        wr_take     = avs_write & bus_done & avs_byteenable[0];
   wire [7:0]  wdat        = avs_writedata[7:0];

   wire        sel_ctrl    = (avs_address == `WDT_IDX_CTRL);
   wire        sel_key     = (avs_address == `WDT_IDX_KEY);
   wire        sel_ien     = (avs_address == `WDT_IDX_IEN);
   wire        sel_stat    = (avs_address == `WDT_IDX_STAT);
   wire        sel_mask    = (avs_address == `WDT_IDX_MASK);
   wire        sel_count   = (avs_address == `WDT_IDX_COUNT);
   wire        sel_state   = (avs_address == `WDT_IDX_STATE);

   wire        ctrl_wr     = wr_take & sel_ctrl;
   wire        key_wr      = wr_take & sel_key;
   wire        ien_wr      = wr_take & sel_ien;
   wire        stat_wr     = wr_take & sel_stat;
   wire        mask_wr     = wr_take & sel_mask;

   assign avs_waitrequest = bus_req & ~ack_reg;

   // timed-access unlock
   wdt_ta_if ta_bus ();

   assign ta_bus.key_wr   = key_wr;
   assign ta_bus.key_data = wdat;
   assign ta_bus.consume  = ctrl_wr;

   wdt_timed_access u_ta (
      .clock   (clock),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .ta      (ta_bus.ta)
   );

   // unguarded writes still reach the cause flag, nothing else
   wire        prot_wr     = ctrl_wr & ta_bus.open;
   wire        restart     = prot_wr & wdat[`WDT_CTRL_RESTART];

   // state decode
   wire        in_count    = (state_reg == WDT_ST_COUNT);
   wire        in_grace    = (state_reg == WDT_ST_GRACE);
   wire        in_reset    = (state_reg == WDT_ST_RESET);

   // time-out divider
   logic [`WDT_DIV_W-1:0]       div_count;
   logic [`WDT_DIV_W-1:0]       div_limit;
   wire                         div_hit;
   // a restart in the same cycle as the hit wins; no time-out is seen
   wire                         div_clear = restart | in_reset;
   wire                         div_run   = run_reg & ~in_reset;

   always_comb begin
      unique case (sel_reg)
         2'h0: div_limit = TO0_LAST[`WDT_DIV_W-1:0];
         2'h1: div_limit = TO1_LAST[`WDT_DIV_W-1:0];
         2'h2: div_limit = TO2_LAST[`WDT_DIV_W-1:0];
         2'h3: div_limit = TO3_LAST[`WDT_DIV_W-1:0];
      endcase
   end

   // wraps on the hit, so the interval repeats without software help
   wdt_cnt #(.W(`WDT_DIV_W)) u_div (
      .clock   (clock),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .clear   (div_clear),
      .run     (div_run),
      .limit   (div_limit),
      .count   (div_count),
      .hit     (div_hit)
   );

   // grace span after each time-out
   logic [`WDT_GRACE_W-1:0]     grace_count;
   wire                         grace_hit;
   wire                         grace_clear = ~in_grace | restart;

   wdt_cnt #(.W(`WDT_GRACE_W)) u_grace (
      .clock   (clock),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .clear   (grace_clear),
      .run     (in_grace),
      .limit   (GRACE_LAST[`WDT_GRACE_W-1:0]),
      .count   (grace_count),
      .hit     (grace_hit)
   );

   // reset pulse length
   logic [`WDT_HOLD_W-1:0]      hold_count;
   wire                         hold_hit;

   wdt_cnt #(.W(`WDT_HOLD_W)) u_hold (
      .clock   (clock),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .clear   (~in_reset),
      .run     (in_reset),
      .limit   (HOLD_LAST[`WDT_HOLD_W-1:0]),
      .count   (hold_count),
      .hit     (hold_hit)
   );

   // sequencer
   // reset-enable only steers the end of the grace span
   wire        grace_end   = in_grace & grace_hit;
   wire        reset_entry = grace_end & rst_en_reg;
   wire        timeout_ev  = div_hit;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         WDT_ST_COUNT: begin
            if (timeout_ev) state_next = WDT_ST_GRACE;
         end
         WDT_ST_GRACE: begin
            if (restart) state_next = WDT_ST_COUNT;
            else if (reset_entry) state_next = WDT_ST_RESET;
            else if (grace_end) state_next = WDT_ST_COUNT;
         end
         WDT_ST_RESET: begin
            if (hold_hit) state_next = WDT_ST_COUNT;
         end
         default: state_next = WDT_ST_COUNT;
      endcase
   end

   // control fields
   // the watchdog's own reset leaves run, select and enable alone
   assign run_next    = prot_wr ? wdat[`WDT_CTRL_RUN] : run_reg;
   assign sel_next    = prot_wr ? wdat[`WDT_CTRL_SEL_HI:`WDT_CTRL_SEL_LO] : sel_reg;
   assign rst_en_next = prot_wr ? wdat[`WDT_CTRL_RST_EN] : rst_en_reg;

   // set wins over a clearing write landing in the same cycle
   assign flag_next   = timeout_ev  ? 1'b1 :
                        reset_entry ? 1'b0 :
                        prot_wr     ? wdat[`WDT_CTRL_FLAG] : flag_reg;

   // only a zero write clears it; guarded writes are not needed here
   assign cause_next  = reset_entry ? 1'b1 :
                        (ctrl_wr && !wdat[`WDT_CTRL_CAUSE]) ? 1'b0 : cause_reg;

   assign ext_en_next = ien_wr ? wdat[`WDT_IEN_EXT]    : ext_en_reg;
   assign glb_en_next = ien_wr ? wdat[`WDT_IEN_GLOBAL] : glb_en_reg;

   // event status, write one to clear, events win
   wire [`WDT_EV_W-1:0] events   = {reset_entry, timeout_ev};
   wire [`WDT_EV_W-1:0] stat_clr = stat_wr ? wdat[`WDT_EV_W-1:0] : '0;

   assign stat_next = events | (stat_reg & ~stat_clr);
   assign mask_next = mask_wr ? wdat[`WDT_EV_W-1:0] : mask_reg;

   wire   irq_next      = |(stat_next & mask_next);
   wire   wd_irq_next   = flag_next & ext_en_next & glb_en_next;

   // read data
   wire [7:0]  ctrl_view = {run_reg, 1'b0, sel_reg, flag_reg, cause_reg, rst_en_reg, 1'b0};
   wire [7:0]  ien_view  = {glb_en_reg, 2'h0, ext_en_reg, 4'h0};
   wire [7:0]  state_view = {4'h0, ta_bus.open, state_reg};

   wire [31:0] rd_mux =
      sel_ctrl  ? {24'h000000, ctrl_view}  :
      sel_ien   ? {24'h000000, ien_view}   :
      sel_stat  ? {{(32-`WDT_EV_W){1'b0}}, stat_reg} :
      sel_mask  ? {{(32-`WDT_EV_W){1'b0}}, mask_reg} :
      sel_count ? {{(32-`WDT_DIV_W){1'b0}}, div_count} :
      sel_state ? {24'h000000, state_view} :
                  32'h00000000;

   // flops
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else if (clk_en) begin
         ack_reg   <= bus_req & ~ack_reg;
         if (avs_read && !ack_reg) rdata_reg <= rd_mux;
      end
   end

   // power-on/fail reset: watchdog stopped, shortest interval
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg  <= WDT_ST_COUNT;
         run_reg    <= 1'b0;
         sel_reg    <= `WDT_SEL_RESET;
         flag_reg   <= 1'b0;
         cause_reg  <= 1'b0;
         rst_en_reg <= 1'b0;
         ext_en_reg <= 1'b0;
         glb_en_reg <= 1'b0;
      end else if (clk_en) begin
         state_reg  <= state_next;
         run_reg    <= run_next;
         sel_reg    <= sel_next;
         flag_reg   <= flag_next;
         cause_reg  <= cause_next;
         rst_en_reg <= rst_en_next;
         ext_en_reg <= ext_en_next;
         glb_en_reg <= glb_en_next;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stat_reg        <= '0;
         mask_reg        <= '0;
         irq             <= 1'b0;
         timeout_irq_req <= 1'b0;
         wd_sys_reset    <= 1'b0;
      end else if (clk_en) begin
         stat_reg        <= stat_next;
         mask_reg        <= mask_next;
         irq             <= irq_next;
         timeout_irq_req <= wd_irq_next;
         wd_sys_reset    <= (state_next == WDT_ST_RESET);
      end
   end

   assign avs_readdata = rdata_reg;

endmodule : wdt_watchdog_timer
`default_nettype wire

// [logic/wdt_cfg.svh]
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

`define WDT_IDX_CTRL        3'h0
`define WDT_IDX_KEY         3'h1
`define WDT_IDX_IEN         3'h2
`define WDT_IDX_STAT        3'h3
`define WDT_IDX_MASK        3'h4
`define WDT_IDX_COUNT       3'h5
`define WDT_IDX_STATE       3'h6

`define WDT_CTRL_RESTART    0
`define WDT_CTRL_RST_EN     1
`define WDT_CTRL_CAUSE      2
`define WDT_CTRL_FLAG       3
`define WDT_CTRL_SEL_LO     4
`define WDT_CTRL_SEL_HI     5
`define WDT_CTRL_RUN        7
`define WDT_SEL_RESET       2'h0

`define WDT_IEN_EXT         4
`define WDT_IEN_GLOBAL      7

`define WDT_EV_TIMEOUT      0
`define WDT_EV_WDRESET      1
`define WDT_EV_W            2

`define WDT_DIV_W           27
`define WDT_TIMEOUT_0       131072
`define WDT_TIMEOUT_1       1048576
`define WDT_TIMEOUT_2       8388608
`define WDT_TIMEOUT_3       67108864

`define WDT_GRACE_CLKS      512
`define WDT_GRACE_W         9
`define WDT_MC_CLKS         4
`define WDT_HOLD_CLKS       (2 * `WDT_MC_CLKS)
`define WDT_HOLD_W          3

`define WDT_KEY_FIRST       8'hAA
`define WDT_KEY_SECOND      8'h55
`define WDT_TA_WINDOW_CLKS  8
`define WDT_TA_W            3

`endif

// [logic/wdt_pkg.sv]
package wdt_pkg;

   typedef enum logic [2:0] {
      WDT_ST_COUNT = 3'b001,
      WDT_ST_GRACE = 3'b010,
      WDT_ST_RESET = 3'b100
   } wdt_state_t;

   typedef enum logic [2:0] {
      WDT_TA_IDLE  = 3'b001,
      WDT_TA_ARMED = 3'b010,
      WDT_TA_OPEN  = 3'b100
   } wdt_ta_state_t;

endpackage : wdt_pkg

// [logic/wdt_ta_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface wdt_ta_if;
   logic       key_wr;
   logic [7:0] key_data;
   logic       consume;
   logic       open;
   modport ta   (input key_wr, input key_data, input consume, output open);
   modport core (output key_wr, output key_data, output consume, input open);
endinterface : wdt_ta_if
`default_nettype wire

// [logic/wdt_cnt.sv]
`timescale 1ns/1ps
`default_nettype none
module wdt_cnt #(
   parameter int W = 8
) (
   input  wire logic         clock,
   input  wire logic         reset_n,
   input  wire logic         clk_en,
   input  wire logic         clear,
   input  wire logic         run,
   input  wire logic [W-1:0] limit,
   output var  logic [W-1:0] count,
   output wire logic         hit
);
   wire [W-1:0] count_inc = count + {{(W-1){1'b0}}, 1'b1};

   assign hit = run & ~clear & (count == limit);

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         count <= '0;
      end else if (clk_en) begin
         if (clear) begin
            count <= '0;
         end else if (run) begin
            count <= hit ? '0 : count_inc;
         end
      end
   end
endmodule : wdt_cnt
`default_nettype wire

// [logic/wdt_timed_access.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_timed_access
   import wdt_pkg::*;
(
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic clk_en,
   wdt_ta_if.ta      ta
);
   localparam int TA_LAST_I = `WDT_TA_WINDOW_CLKS - 1;

   wdt_ta_state_t             state_reg;
   wdt_ta_state_t             state_next;
   logic [`WDT_TA_W-1:0]      win_reg;

   wire key_first  = ta.key_wr & (ta.key_data == `WDT_KEY_FIRST);
   wire key_second = ta.key_wr & (ta.key_data == `WDT_KEY_SECOND);
   wire win_done   = (win_reg == TA_LAST_I[`WDT_TA_W-1:0]);

   // window closes on use, on timeout, or on any stray key write
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         WDT_TA_IDLE:  if (key_first) state_next = WDT_TA_ARMED;
         WDT_TA_ARMED: if (ta.key_wr) state_next = key_second ? WDT_TA_OPEN : WDT_TA_IDLE;
         WDT_TA_OPEN: begin
            if (ta.consume || win_done) state_next = WDT_TA_IDLE;
            else if (ta.key_wr) state_next = key_first ? WDT_TA_ARMED : WDT_TA_IDLE;
         end
         default:      state_next = WDT_TA_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= WDT_TA_IDLE;
         win_reg   <= '0;
      end else if (clk_en) begin
         state_reg <= state_next;
         win_reg   <= (state_reg == WDT_TA_OPEN) ? win_reg + {{(`WDT_TA_W-1){1'b0}}, 1'b1} : '0;
      end
   end

   assign ta.open = (state_reg == WDT_TA_OPEN);
endmodule : wdt_timed_access
`default_nettype wire

// [logic/wdt_pkg_order_note.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [tb/wdt_watchdog_timer_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_watchdog_timer_asserts
   import wdt_pkg::*;
(
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic        clk_en,
   input wire logic [2:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        irq,
   input wire logic        timeout_irq_req,
   input wire logic        wd_sys_reset
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence s_rd(logic [2:0] idx);
      avs_read && !avs_waitrequest && avs_address == idx;
   endsequence
   // eight clocks high, then released
   sequence s_hold;
      wd_sys_reset [*8] ##1 !wd_sys_reset;
   endsequence

   a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en
      |=> !avs_waitrequest) else $error("bus answer late");
   a_wait_idle_low: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest without request");
   a_reset_quiet: assert property (
      $rose(reset_n) |-> !irq && !wd_sys_reset && !timeout_irq_req)
      else $error("outputs active after reset");
   a_ctrl_fixed_zero: assert property (s_rd(`WDT_IDX_CTRL) |->
      avs_readdata[31:8] == 24'h0 && !avs_readdata[6] && !avs_readdata[0])
      else $error("restart bit reads back");
   a_key_reads_zero: assert property (s_rd(`WDT_IDX_KEY) |-> avs_readdata == 32'h0)
      else $error("key register readable");
   a_unmapped_zero: assert property (s_rd(3'h7) |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_state_one_hot: assert property (s_rd(`WDT_IDX_STATE) |-> $onehot(avs_readdata[2:0]))
      else $error("state not one-hot");
   a_hold_eight: assert property ($rose(wd_sys_reset) |-> s_hold)
      else $error("system reset length wrong");
   a_req_cleared: assert property ($rose(wd_sys_reset) |-> ##[0:1] !timeout_irq_req)
      else $error("flag survives watchdog reset");
endmodule : wdt_watchdog_timer_asserts

bind wdt_watchdog_timer wdt_watchdog_timer_asserts chk_u (.clock, .reset_n, .clk_en,
   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .irq, .timeout_irq_req, .wd_sys_reset);
`default_nettype wire

// [tb/wdt_watchdog_timer_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_watchdog_timer_tb_top import wdt_pkg::*; ;
   // short intervals, all well above the 512 clock grace
   localparam int T0 = 2048;
   localparam int T1 = 4096;
   localparam int T2 = 8192;
   localparam int T3 = 16384;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        clk_en = 1'b1;
   logic [2:0]  avs_address = 3'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        irq;
   logic        timeout_irq_req;
   logic        wd_sys_reset;
   logic [31:0] rd;
   int          miscompares = 0;
   int          checks = 0;
   int          cyc = 0;
   int          n;
   int          tmo[4] = '{T0, T1, T2, T3};
   logic [2:0]  row_a[8] = '{`WDT_IDX_CTRL, `WDT_IDX_KEY, `WDT_IDX_IEN, `WDT_IDX_STAT,
                             `WDT_IDX_MASK, `WDT_IDX_COUNT, `WDT_IDX_STATE, 3'h7};
   logic [31:0] row_d[8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
   logic [7:0]  ien_v[3] = '{8'h10, 8'h80, 8'h90};

   always #12.5 clock = ~clock;

   wdt_watchdog_timer #(.TIMEOUT_CLKS_0(T0), .TIMEOUT_CLKS_1(T1), .TIMEOUT_CLKS_2(T2),
      .TIMEOUT_CLKS_3(T3)) dut_u (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
      .timeout_irq_req(timeout_irq_req), .wd_sys_reset(wd_sys_reset));

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      // no wait limit here; the bench timeout ends a hung access
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task guarded(input logic [7:0] d);
      bus(1'b1, `WDT_IDX_KEY, `WDT_KEY_FIRST);
      bus(1'b1, `WDT_IDX_KEY, `WDT_KEY_SECOND);
      bus(1'b1, `WDT_IDX_CTRL, d);
   endtask : guarded

   task wait_for(input logic sys, input int lim);
      n = 0;
      // look from the next edge on, so a level cleared just now is not seen stale
      do begin
         @(posedge clock);
         n++;
      end while (((sys ? wd_sys_reset : irq) !== 1'b1) && n < lim);
   endtask : wait_for

   task in_range(input int lo, input int hi);
      chk(32'(n >= lo && n <= hi), 32'h1);
   endtask : in_range

   task finish_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         miscompares++;
         finish_test();
      end
   end

   initial begin
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, row_a[i], 8'h00);
         chk(rd, row_d[i]);
      end
      bus(1'b1, `WDT_IDX_CTRL, 8'hB2);
      bus(1'b0, `WDT_IDX_CTRL, 8'h00);
      chk(rd, 32'h0);
      // unlocked, but the window runs out before the write
      bus(1'b1, `WDT_IDX_KEY, `WDT_KEY_FIRST);
      bus(1'b1, `WDT_IDX_KEY, `WDT_KEY_SECOND);
      repeat (10) @(posedge clock);
      bus(1'b1, `WDT_IDX_CTRL, 8'h81);
      bus(1'b0, `WDT_IDX_CTRL, 8'h00);
      chk(rd, 32'h0);
      bus(1'b1, `WDT_IDX_MASK, 8'h03);
      for (int i = 0; i < 4; i++) begin
         guarded(8'(8'h81 | (i << 4)));
         bus(1'b0, `WDT_IDX_CTRL, 8'h00);
         chk(rd, 32'(8'h80 | (i << 4)));
         bus(1'b1, `WDT_IDX_STAT, 8'h03);
         wait_for(1'b0, T3 + 50);
         in_range(tmo[i] - 8, tmo[i]);
         bus(1'b0, `WDT_IDX_CTRL, 8'h00);
         chk(32'(rd[3]), 32'h1);
      end
      bus(1'b1, `WDT_IDX_STAT, 8'h01);
      wait_for(1'b0, T3 + 50);
      in_range(T3 - 20, T3);
      repeat (600) @(posedge clock);
      chk(32'(wd_sys_reset), 32'h0);
      for (int j = 0; j < 3; j++) begin
         bus(1'b1, `WDT_IDX_IEN, ien_v[j]);
         repeat (3) @(posedge clock);
         chk(32'(timeout_irq_req), 32'(j == 2));
      end
      guarded(8'h83);
      wait_for(1'b1, T0 + 700);
      in_range(T0 + 508, T0 + 516);
      repeat (10) @(posedge clock);
      bus(1'b0, `WDT_IDX_CTRL, 8'h00);
      chk(rd, 32'h86);
      bus(1'b0, `WDT_IDX_STAT, 8'h00);
      chk(32'(rd[1]), 32'h1);
      // cause clears without the key, the rest stays
      bus(1'b1, `WDT_IDX_CTRL, 8'h00);
      bus(1'b0, `WDT_IDX_CTRL, 8'h00);
      chk(rd, 32'h82);
      bus(1'b1, `WDT_IDX_STAT, 8'h03);
      wait_for(1'b0, T0 + 50);
      chk(32'(n < T0 + 50), 32'h1);
      repeat (200) @(posedge clock);
      guarded(8'h83);
      wait_for(1'b1, 700);
      chk(32'(n), 32'd700);
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      bus(1'b0, `WDT_IDX_CTRL, 8'h00);
      chk(rd, 32'h0);
      repeat (20) @(posedge clock);
      bus(1'b0, `WDT_IDX_COUNT, 8'h00);
      chk(rd, 32'h0);
      finish_test();
   end
endmodule : wdt_watchdog_timer_tb_top
`default_nettype wire
